// File: fdc_gate_pkg.sv
// Summary of operation
// - Direction pin driven only during seeks
// - Step pin seek-only; no fault reset output
// - Status three bit seven reads zero
// - Track zero sampled only while seeking
// - Status three bits six, three: write protect
// - Every drive always reported ready
// - Reset raises ready-change interrupt until sensed
// - Seek indication internal, gates drive pins
// - Reduced current pin, spindle speed in compat
// - Step low 24, cycle 132 media clocks
// - Direction stable 4 clocks before step
// - Direction held 96 clocks after step
// - Unit select held 20 after step
// - Interrupt drops within one media clock
// Shared constants and carriers for the drive gating block.
// Assumes a 20 MHz system clock and an AXI4-Lite register master.
package fdc_gate_pkg;

    // Clock
    localparam int CLK_MHZ = 20;

    // Media clock period per data rate, in ns
    localparam int MCY_NS_R0 = 200;
    localparam int MCY_NS_R1 = 400;
    localparam int MCY_NS_R2 = 500;
    localparam int MCY_NS_R3 = 800;
    localparam int MCY_CYC_R0 = (MCY_NS_R0 * CLK_MHZ) / 1000;
    localparam int MCY_CYC_R1 = (MCY_NS_R1 * CLK_MHZ) / 1000;
    localparam int MCY_CYC_R2 = (MCY_NS_R2 * CLK_MHZ) / 1000;
    localparam int MCY_CYC_R3 = (MCY_NS_R3 * CLK_MHZ) / 1000;

    // Drive timing, in media clock periods
    localparam int STEP_LOW_MCY  = 24;
    localparam int STEP_CYC_MCY  = 132;
    localparam int DIR_SETUP_MCY = 4;
    localparam int DIR_HOLD_MCY  = 96;
    localparam int SEL_HOLD_MCY  = 20;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SEEK    = 8'h04;
    localparam logic [7:0] OFS_STATUS3 = 8'h08;
    localparam logic [7:0] OFS_INTSTAT = 8'h0C;

    // Status three bit positions
    localparam int S3_UNIT  = 0;
    localparam int S3_WP_LO = 3;
    localparam int S3_TZ    = 4;
    localparam int S3_RDY   = 5;
    localparam int S3_WP_HI = 6;
    localparam int S3_FLT   = 7;

    // Interrupt cause codes in status zero bits 7:5
    localparam logic [2:0] CAUSE_READY  = 3'b110;
    localparam logic [2:0] CAUSE_NORMAL = 3'b001;
    localparam logic [2:0] CAUSE_ABNORM = 3'b011;

    // Rate code selecting spindle speed in compat mode
    localparam logic [1:0] RATE_SPINDLE = 2'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [11:0] stepCycle;
        logic        reducedCurrent;
        logic        compatMode;
        logic [1:0]  rate;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{stepCycle: 12'h084,
        reducedCurrent: 1'b0, compatMode: 1'b0, rate: 2'h0};

    typedef struct packed {
        logic       recal;
        logic       dir;
        logic [1:0] unit;
        logic [7:0] count;
    } seek_cmd_t;

    typedef struct packed {
        logic       headDirection;
        logic       stepN;
        logic [1:0] unitSelect;
        logic       rwcSpindle;
    } drive_pins_t;

endpackage

// File: mclk_tick.sv
// Media clock tick generator: one pulse per media clock period.
// Assumes the divisor stays at least 1 and changes only between seeks.
`timescale 1ns/100ps
module mclk_tick #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Period in system clocks
    input  wire logic [CNT_W-1:0] divisor,
    // Tick out
    output logic                  tick
);
    logic [CNT_W-1:0] cnt_q;

    // Elaboration refuses a counter too narrow to divide
    if (CNT_W < 2) begin : g_width_check
        $error("mclk_tick: CNT_W too small");
    end

    always_ff @(posedge clk_sys) begin
        if (reset || cnt_q >= divisor - CNT_W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q >= divisor - CNT_W'(1));
        end
    end
endmodule

// File: fdc_drive_gate.sv
// Drive gating, step timing and drive status with an AXI4-Lite slave.
// Assumes drive inputs are synchronous to clk_sys and active high.
`timescale 1ns/100ps
module fdc_drive_gate (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    // AXI4-Lite write address
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [7:0]                 s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    // AXI4-Lite write response
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [7:0]                 s_axi_araddr,
    // AXI4-Lite read data
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // Drive side
    input  wire logic                       trackZero,
    input  wire logic                       writeProtect,
    output fdc_gate_pkg::drive_pins_t       drivePins,
    // Host interrupt
    output logic                            irq
);
    import fdc_gate_pkg::*;

    typedef enum {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_HOLD} seek_state_t;

    seek_state_t state_q;
    ctrl_t       ctrl_q;
    seek_cmd_t   cmd_q;
    logic [7:0]  remain_q;
    logic [11:0] cnt_q;
    logic        tzSeen_q;
    logic        irq_q;
    logic [2:0]  cause_q;
    logic        mTick;
    logic [7:0]  divisor;
    logic        seeking;
    logic [11:0] highTicks;
    logic        awHeld_q;
    logic        wHeld_q;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wrDo;
    logic        rdDo;
    logic        senseWr;
    logic        seekWr;
    logic        finish;
    logic [2:0]  finishCause;
    logic [7:0]  status3;

    // Rate selects the media clock period
    always_comb begin
        case (ctrl_q.rate)
            2'h0:    divisor = 8'(MCY_CYC_R0);
            2'h1:    divisor = 8'(MCY_CYC_R1);
            2'h2:    divisor = 8'(MCY_CYC_R2);
            default: divisor = 8'(MCY_CYC_R3);
        endcase
    end

    mclk_tick #(
        .CNT_W (8)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset   (reset),
        .divisor (divisor),
        .tick    (mTick)
    );

    // Internal read/write-versus-seek indication, never a pin
    assign seeking = (state_q != S_IDLE);

    // Programmed step cycle never below the minimum
    always_comb begin
        if (ctrl_q.stepCycle < 12'(STEP_CYC_MCY)) begin
            highTicks = 12'(STEP_CYC_MCY - STEP_LOW_MCY);
        end else begin
            highTicks = ctrl_q.stepCycle - 12'(STEP_LOW_MCY);
        end
    end

    // Bus handshakes: address and data taken in either order
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign wrDo          = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rdDo          = s_axi_arvalid && s_axi_arready;
    assign senseWr = wrDo && awAddr_q == OFS_INTSTAT && wStrb_q[0];
    assign seekWr  = wrDo && awAddr_q == OFS_SEEK && !seeking
                     && wStrb_q[1] && wStrb_q[0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (wrDo) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (wrDo) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wrDo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == OFS_STATUS3 ||
                             awAddr_q > OFS_INTSTAT) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register, byte lanes honoured
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
        end else if (wrDo && awAddr_q == OFS_CTRL) begin
            if (wStrb_q[0]) begin
                ctrl_q.rate           <= wData_q[1:0];
                ctrl_q.compatMode     <= wData_q[2];
                ctrl_q.reducedCurrent <= wData_q[3];
            end
            if (wStrb_q[1]) begin
                ctrl_q.stepCycle[7:0] <= wData_q[15:8];
            end
            if (wStrb_q[2]) begin
                ctrl_q.stepCycle[11:8] <= wData_q[19:16];
            end
        end
    end

    // Every drive reads as ready; fault and two-sided are gone
    always_comb begin
        status3                = 8'h00;
        status3[S3_UNIT +: 2]  = cmd_q.unit;
        status3[S3_WP_LO]      = writeProtect;
        status3[S3_TZ]         = tzSeen_q;
        status3[S3_RDY]        = 1'b1;
        status3[S3_WP_HI]      = writeProtect;
        status3[S3_FLT]        = 1'b0;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rdDo) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                OFS_CTRL:    s_axi_rdata <= {12'h000, ctrl_q.stepCycle,
                                 4'h0, ctrl_q.reducedCurrent,
                                 ctrl_q.compatMode, ctrl_q.rate};
                OFS_SEEK:    s_axi_rdata <= {16'h0000, remain_q,
                                 7'h00, seeking};
                OFS_STATUS3: s_axi_rdata <= {24'h00_0000, status3};
                OFS_INTSTAT: s_axi_rdata <= {24'h00_0000, cause_q,
                                 4'h0, irq_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Seek sequencer, all intervals in media clock ticks
    always_comb begin
        finish      = 1'b0;
        finishCause = CAUSE_NORMAL;
        if (mTick && state_q == S_HOLD && cnt_q == 12'(DIR_HOLD_MCY)) begin
            finish      = 1'b1;
            finishCause = (cmd_q.recal && !tzSeen_q) ? CAUSE_ABNORM
                                                      : CAUSE_NORMAL;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q  <= S_IDLE;
            cnt_q    <= 12'h000;
            remain_q <= 8'h00;
            cmd_q    <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    cnt_q <= 12'h000;
                    if (seekWr) begin
                        cmd_q    <= {wData_q[3], wData_q[2],
                                     wData_q[1:0], wData_q[15:8]};
                        remain_q <= wData_q[15:8];
                        state_q  <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (mTick) begin
                        cnt_q <= cnt_q + 12'h001;
                        if (cnt_q == 12'(DIR_SETUP_MCY)) begin
                            cnt_q <= 12'h000;
                            if (remain_q == 8'h00 ||
                                (cmd_q.recal && trackZero)) begin
                                state_q <= S_HOLD;
                            end else begin
                                state_q <= S_LOW;
                            end
                        end
                    end
                end
                S_LOW: begin
                    if (mTick) begin
                        cnt_q <= cnt_q + 12'h001;
                        if (cnt_q == 12'(STEP_LOW_MCY)) begin
                            cnt_q    <= 12'h000;
                            remain_q <= remain_q - 8'h01;
                            state_q  <= S_HIGH;
                        end
                    end
                end
                S_HIGH: begin
                    if (mTick) begin
                        cnt_q <= cnt_q + 12'h001;
                        if (cnt_q == highTicks) begin
                            cnt_q <= 12'h000;
                            if (remain_q == 8'h00 ||
                                (cmd_q.recal && trackZero)) begin
                                state_q <= S_HOLD;
                            end else begin
                                state_q <= S_LOW;
                            end
                        end
                    end
                end
                S_HOLD: begin
                    if (mTick) begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                    if (finish) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Track zero looked at only while a seek runs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tzSeen_q <= 1'b0;
        end else if (seeking) begin
            tzSeen_q <= trackZero;
        end
    end

    // Ready seen at reset counts as a change; set beats sense
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_q   <= 1'b1;
            cause_q <= CAUSE_READY;
        end else if (finish) begin
            irq_q   <= 1'b1;
            cause_q <= finishCause;
        end else if (senseWr) begin
            irq_q   <= 1'b0;
        end
    end
    assign irq = irq_q;

    // Direction and step pins forced idle outside seeks to save power
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drivePins <= '{headDirection: 1'b1, stepN: 1'b1,
                           unitSelect: 2'h0, rwcSpindle: 1'b0};
        end else begin
            drivePins.headDirection <= seeking ? cmd_q.dir : 1'b1;
            drivePins.stepN <= !(state_q == S_LOW);
            drivePins.unitSelect <= cmd_q.unit;
            drivePins.rwcSpindle <= ctrl_q.compatMode
                ? (ctrl_q.rate == RATE_SPINDLE)
                : (ctrl_q.reducedCurrent && !seeking);
        end
    end

    // Helper tick counters for the timing checks
    logic [11:0] lowTicks_q;
    logic [11:0] fallTicks_q;
    logic [11:0] riseTicks_q;
    logic [11:0] dirTicks_q;
    logic        pinDirPrev_q;
    logic        stepPrev_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lowTicks_q   <= 12'h000;
            fallTicks_q  <= 12'hFFF;
            riseTicks_q  <= 12'hFFF;
            dirTicks_q   <= 12'hFFF;
            pinDirPrev_q <= 1'b1;
            stepPrev_q   <= 1'b1;
        end else begin
            pinDirPrev_q <= drivePins.headDirection;
            stepPrev_q   <= drivePins.stepN;
            lowTicks_q   <= drivePins.stepN ? 12'h000
                          : lowTicks_q + 12'(mTick);
            fallTicks_q  <= (stepPrev_q && !drivePins.stepN) ? 12'h000
                          : fallTicks_q + 12'(mTick && fallTicks_q != 12'hFFF);
            riseTicks_q  <= (!stepPrev_q && drivePins.stepN) ? 12'h000
                          : riseTicks_q + 12'(mTick && riseTicks_q != 12'hFFF);
            dirTicks_q   <= (pinDirPrev_q != drivePins.headDirection)
                          ? 12'h000
                          : dirTicks_q + 12'(mTick && dirTicks_q != 12'hFFF);
        end
    end

    property p_fault_zero;
        @(posedge clk_sys) disable iff (reset)
        status3[S3_FLT] == 1'b0;
    endproperty
    a_fault_zero: assert property (p_fault_zero)
        else $error("fault bit not zero");

    property p_wp_mirror;
        @(posedge clk_sys) disable iff (reset)
        status3[S3_WP_HI] == writeProtect && status3[S3_WP_LO] == writeProtect
        && status3[S3_RDY];
    endproperty
    a_wp_mirror: assert property (p_wp_mirror)
        else $error("status three mirror or ready wrong");

    property p_reset_irq;
        @(posedge clk_sys) disable iff (reset)
        $past(reset) |-> irq && cause_q == CAUSE_READY;
    endproperty
    a_reset_irq: assert property (p_reset_irq)
        else $error("no ready interrupt after reset");

    sequence s_sense_taken;
        senseWr && !finish;
    endsequence
    property p_irq_clear;
        @(posedge clk_sys) disable iff (reset)
        s_sense_taken |=> !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt not cleared by sense");

    property p_dir_idle;
        @(posedge clk_sys) disable iff (reset)
        !seeking ##1 !seeking |-> drivePins.headDirection && drivePins.stepN;
    endproperty
    a_dir_idle: assert property (p_dir_idle)
        else $error("drive pin active outside seek");

    property p_tz_ignored;
        @(posedge clk_sys) disable iff (reset)
        !seeking |=> $stable(tzSeen_q);
    endproperty
    a_tz_ignored: assert property (p_tz_ignored)
        else $error("track zero sampled while idle");

    property p_step_low;
        @(posedge clk_sys) disable iff (reset)
        $rose(drivePins.stepN) |-> $past(lowTicks_q) >= 12'(STEP_LOW_MCY);
    endproperty
    a_step_low: assert property (p_step_low)
        else $error("step pulse too short");

    property p_step_cycle;
        @(posedge clk_sys) disable iff (reset)
        $fell(drivePins.stepN) |-> fallTicks_q >= 12'(STEP_CYC_MCY);
    endproperty
    a_step_cycle: assert property (p_step_cycle)
        else $error("step cycle too short");

    property p_dir_setup;
        @(posedge clk_sys) disable iff (reset)
        $fell(drivePins.stepN) |-> $past(dirTicks_q) >= 12'(DIR_SETUP_MCY);
    endproperty
    a_dir_setup: assert property (p_dir_setup)
        else $error("direction setup too short");

    property p_dir_hold;
        @(posedge clk_sys) disable iff (reset)
        $changed(drivePins.headDirection) |->
            $past(riseTicks_q) >= 12'(DIR_HOLD_MCY);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed too soon after step");

    property p_sel_hold;
        @(posedge clk_sys) disable iff (reset)
        $changed(drivePins.unitSelect) |->
            $past(fallTicks_q) >= 12'(SEL_HOLD_MCY);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("unit select changed too soon");
endmodule

// File: drive_model.sv
// Floppy drive mechanism: head position moved by step pulses.
// Assumes pins come straight from the gating block, active levels as declared.
`timescale 1ns/100ps
module drive_model (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // Cable from the controller
    input  wire fdc_gate_pkg::drive_pins_t pins,
    input  wire logic                 tzForce,
    output logic                      trackZero
);
    import fdc_gate_pkg::*;

    int   track;
    logic prevStep;

    // Head moves on the falling step edge; cannot go below track 0
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            track    <= 0;
            prevStep <= 1'b1;
        end else begin
            prevStep <= pins.stepN;
            if (prevStep && !pins.stepN) begin
                track <= pins.headDirection ? track + 1 :
                         (track > 0 ? track - 1 : 0);
            end
        end
    end

    // Forced level lets a test show the input is ignored when idle
    assign trackZero = (track == 0) || tzForce;
endmodule

// File: test_fdc_drive_gate.sv
// Self-checking bench: AXI4-Lite master, drive model, step timing monitor.
// Assumes rate code 0 after reset, so one media clock is MCY_CYC_R0 clocks.
`timescale 1ns/100ps
module test_fdc_drive_gate;
    import fdc_gate_pkg::*;
    localparam int M = MCY_CYC_R0;
    logic clkSys = 0, reset = 1, wp = 0, tzForce = 0, seekOn = 0;
    logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic [7:0] awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0, d;
    logic [3:0] wStrb = 0;
    logic awReady, wReady, bValid, arReady, rValid, irq, trackZero;
    logic [1:0] bResp, rResp, r, pSel = 0;
    logic [31:0] rData;
    logic pStep = 1, pDir = 1;
    drive_pins_t pins;
    int n_fail = 0, cmp_count = 0, lowN = 0;
    int sinceFall = 99999, sinceRise = 99999, dirN = 99999;
    logic [31:0] ctl [4] = '{32'h0000_8408, 32'h0000_8405,
                             32'h0000_8404, 32'h0000_8400};
    logic [3:0] rwcExp = 4'b0011;

    always #25 clkSys = ~clkSys;

    fdc_drive_gate u_dut (.clk_sys(clkSys), .reset(reset),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .trackZero(trackZero), .writeProtect(wp),
        .drivePins(pins), .irq(irq));
    drive_model u_drive (.clk_sys(clkSys), .reset(reset), .pins(pins),
        .tzForce(tzForce), .trackZero(trackZero));

    task automatic end_sim;
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ok(input logic c);
        chk({31'h0, c}, 32'h1);
    endtask
    // Handshake seen at the negedge is taken at the following rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic da, dw, ta, tw;
        da = 0;
        dw = 0;
        @(posedge clkSys);
        awValid <= 1; awAddr <= a; wValid <= 1; wData <= v; wStrb <= 4'hf;
        bReady <= 1;
        while (!(da && dw)) begin
            @(negedge clkSys);
            ta = awValid && awReady;
            tw = wValid && wReady;
            @(posedge clkSys);
            if (ta) begin awValid <= 0; da = 1; end
            if (tw) begin wValid <= 0; dw = 1; end
        end
        do @(negedge clkSys); while (bValid !== 1'b1);
        r = bResp;
        @(posedge clkSys);
        bReady <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clkSys);
        arValid <= 1; arAddr <= a; rReady <= 1;
        do @(negedge clkSys); while (arReady !== 1'b1);
        @(posedge clkSys);
        arValid <= 0;
        do @(negedge clkSys); while (rValid !== 1'b1);
        d = rData;
        r = rResp;
        @(posedge clkSys);
        rReady <= 0;
    endtask
    task automatic sense(input logic [2:0] c);
        rd(OFS_INTSTAT); chk(d & 32'hE1, {24'h0, c, 5'h01});
        wr(OFS_INTSTAT, 32'h1);
        repeat (2) @(negedge clkSys);
        ok(irq === 1'b0);
    endtask
    task automatic seek(input logic [7:0] n, input logic [3:0] op,
                        input logic [2:0] c);
        seekOn = 1;
        wr(OFS_SEEK, {16'h0, n, 4'h0, op});
        rd(OFS_SEEK);
        chk(d & 32'h1, 32'h1);
        while (irq !== 1'b1) @(negedge clkSys);
        sense(c);
        rd(OFS_SEEK);
        chk(d & 32'h1, 32'h0);
        seekOn = 0;
    endtask

    // Pin timing watched on every clock, in system clocks
    always @(posedge clkSys) begin
        if (!reset) begin
            if (pStep && !pins.stepN) begin
                ok(dirN >= DIR_SETUP_MCY * M);
                ok(sinceFall >= STEP_CYC_MCY * M);
                ok(seekOn);
                sinceFall = 0;
            end
            if (!pStep && pins.stepN) ok(lowN >= STEP_LOW_MCY * M);
            if (!pStep && pins.stepN) sinceRise = 0;
            if (pDir !== pins.headDirection) begin
                ok(sinceRise >= DIR_HOLD_MCY * M);
                ok(seekOn);
                dirN = 0;
            end
            if (pSel !== pins.unitSelect)
                ok(sinceFall >= SEL_HOLD_MCY * M);
        end
        lowN = pins.stepN ? 0 : lowN + 1;
        sinceFall++;
        sinceRise++;
        dirN++;
        pStep = pins.stepN;
        pDir = pins.headDirection;
        pSel = pins.unitSelect;
    end

    // Whole run is near 4k clocks; this allows about five times that
    initial begin
        #1_000_000;
        n_fail++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge clkSys);
        reset <= 0;
        repeat (32 * M) @(posedge clkSys);
        ok(irq === 1'b1);
        sense(CAUSE_READY);
        for (int i = 0; i < 2; i++) begin
            wp <= i[0];
            repeat (2) @(posedge clkSys);
            rd(OFS_STATUS3);
            chk(d & 32'hFF, {24'h0, 1'b0, i[0], 2'b10, i[0], 3'b000});
        end
        wp <= 0;
        rd(8'h10); chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(OFS_STATUS3, 32'h0); chk(r, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, ctl[i]);
            repeat (2) @(posedge clkSys);
            ok(pins.rwcSpindle === rwcExp[i]);
        end
        rd(OFS_CTRL);
        chk(d, 32'h0000_8400);
        seek(8'd2, 4'b0110, CAUSE_NORMAL);
        rd(OFS_STATUS3); chk(d & 32'hFF, 32'h0000_0022);
        tzForce <= 1;
        repeat (2) @(posedge clkSys);
        rd(OFS_STATUS3); chk(d & 32'hFF, 32'h0000_0022);
        tzForce <= 0;
        seek(8'd1, 4'b1001, CAUSE_ABNORM);
        seek(8'd3, 4'b1001, CAUSE_NORMAL);
        rd(OFS_STATUS3); chk(d & 32'hFF, 32'h0000_0031);
        // Second reset mid-run: status cleared, ready change again
        reset <= 1;
        repeat (5 * M) @(posedge clkSys);
        reset <= 0;
        repeat (40 * M) @(posedge clkSys);
        ok(irq === 1'b1);
        rd(OFS_STATUS3);
        chk(d & 32'hFF, 32'h0000_0020);
        sense(CAUSE_READY);
        // No DMA, count or index pin here; nothing to hold
        end_sim;
    end
endmodule
